// file: core/serial_master_pkg.sv
`default_nettype none
package serial_master_pkg;
	// register byte addresses, each one aligned word
	localparam logic [31:0] ADDR_SHIFT_DATA = 32'h8000_00d0;
	localparam logic [31:0] ADDR_CONTROL    = 32'h8000_00d4;
	localparam logic [31:0] ADDR_DIVIDER    = 32'h8000_00d8;
	localparam logic [31:0] ADDR_SELECT     = 32'h8000_00dc;

	// transfer_control field positions
	localparam int CTRL_LOOPBACK = 11;
	localparam int CTRL_SCLK_INV = 10;
	localparam int CTRL_IRQ_EN   = 9;
	localparam int CTRL_LSB      = 8;
	localparam int CTRL_LEN_HI   = 7;
	localparam int CTRL_LEN_LO   = 3;
	localparam int CTRL_TX_FALL  = 2;
	localparam int CTRL_RX_FALL  = 1;
	localparam int CTRL_LAUNCH   = 0;
	localparam int CTRL_WIDTH    = 12;
	localparam int SELECT_WIDTH  = 2;

	// reset values
	localparam logic [11:0] CTRL_RESET    = 12'h000;
	localparam logic [15:0] DIVIDER_RESET = 16'h0000;
	localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
	localparam logic [1:0]  SELECT_RESET  = 2'h0;

	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01
	} xfer_state_t;
endpackage : serial_master_pkg
`default_nettype wire

// file: core/serial_master_control.sv
// Added by the designer: the AHB-Lite interface to the registers.
`default_nettype none
module serial_master_control #(
	parameter int DIV_WIDTH = 16,
	parameter int MAX_BITS  = 32
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// serial link
	output logic             sclk,
	output logic             mosi,
	input  wire logic        miso,
	output logic [1:0]       selectN,
	// completion interrupt
	output logic             irq
);
	localparam int CW = $clog2(MAX_BITS + 1);

	// bit position of the n-th bit on the wire within the data word
	function automatic logic [4:0] bitPos(input logic [CW-1:0] count,
		input logic [4:0] lenField, input logic lsbFirst);
		logic [4:0] idx;
		idx = count[4:0];
		if (lsbFirst)
			bitPos = idx;
		else
			bitPos = lenField - idx;
	endfunction : bitPos

	// registers
	localparam int CTRL_WIDTH_L = serial_master_pkg::CTRL_WIDTH;
	logic [31:0]               shiftData;
	logic [CTRL_WIDTH_L-1:0]   control;
	logic [DIV_WIDTH-1:0]      divider;
	logic [1:0]                slaveSel;

	// bus pipeline state
	logic        wrPending;
	logic [31:0] wrAddr;

	// transfer state
	serial_master_pkg::xfer_state_t state;
	logic [31:0]          txWord;
	logic [DIV_WIDTH-1:0] divCount;
	logic                 phase;
	logic [CW:0]          edgeCount;
	logic [CW-1:0]        txCount;
	logic [CW-1:0]        rxCount;

	// control field views
	wire       loopback = control[serial_master_pkg::CTRL_LOOPBACK];
	wire       sclkInv  = control[serial_master_pkg::CTRL_SCLK_INV];
	wire       irqEn    = control[serial_master_pkg::CTRL_IRQ_EN];
	wire       lsbFirst = control[serial_master_pkg::CTRL_LSB];
	wire [4:0] lenField = control[serial_master_pkg::CTRL_LEN_HI:
		serial_master_pkg::CTRL_LEN_LO];
	wire       txFall   = control[serial_master_pkg::CTRL_TX_FALL];
	wire       rxFall   = control[serial_master_pkg::CTRL_RX_FALL];
	wire       launch   = control[serial_master_pkg::CTRL_LAUNCH];

	// address phase decode
	wire addrPhase = hsel & hready & htrans[1];
	wire rdAccess  = addrPhase & ~hwrite;
	wire wrAccess  = addrPhase & hwrite;

	// write decode on the latched data-phase address
	wire wrData = wrPending & (wrAddr == serial_master_pkg::ADDR_SHIFT_DATA);
	wire wrCtrl = wrPending & (wrAddr == serial_master_pkg::ADDR_CONTROL);
	wire wrDiv  = wrPending & (wrAddr == serial_master_pkg::ADDR_DIVIDER);
	wire wrSel  = wrPending & (wrAddr == serial_master_pkg::ADDR_SELECT);

	// read mux, unmapped and write-only locations read zero
	logic [31:0] readValue;
	always_comb begin
		if (haddr == serial_master_pkg::ADDR_SHIFT_DATA)
			readValue = shiftData;
		else if (haddr == serial_master_pkg::ADDR_CONTROL)
			readValue = {{(32-CTRL_WIDTH_L){1'b0}}, control};
		else if (haddr == serial_master_pkg::ADDR_DIVIDER)
			readValue = {{(32-DIV_WIDTH){1'b0}}, divider};
		else
			readValue = 32'h0000_0000;
	end

	// transfer timing: one edge per expired half period
	wire        running   = (state == serial_master_pkg::ST_RUN);
	wire        halfDone  = running & (divCount == '0);
	wire        riseEdge  = halfDone & ~phase;
	wire        fallEdge  = halfDone & phase;
	wire [CW:0] edgeTotal = {CW'(lenField) + CW'(1), 1'b0};
	wire        lastEdge  = halfDone & (edgeCount + 1'b1 == edgeTotal[CW:0]);
	wire        startXfer = ~running & wrCtrl &
		hwdata[serial_master_pkg::CTRL_LAUNCH];
	wire [CW-1:0] nBits   = CW'(lenField) + CW'(1);

	// edge selection for shifting out and sampling in
	wire txEdge  = txFall ? fallEdge : riseEdge;
	wire rxEdge  = rxFall ? fallEdge : riseEdge;
	wire txMore  = txCount < nBits;
	wire rxMore  = rxCount < nBits;
	wire rxBit   = loopback ? ~mosi : miso;
	wire [4:0] txPos = bitPos(txCount, lenField, lsbFirst);
	wire [4:0] rxPos = bitPos(rxCount, lenField, lsbFirst);

	// completion, fires with the last clock edge
	wire xferDone = running & lastEdge;

	// next clock phase, held low while idle
	wire next_phase = running ? (phase ^ halfDone) : 1'b0;

	// bus response, zero wait states, read data registered in address phase
	always_ff @(posedge clk) begin
		if (reset) begin
			hreadyout <= 1'b1;
			hresp     <= serial_master_pkg::HRESP_OKAY;
			hrdata    <= 32'h0000_0000;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= serial_master_pkg::HRESP_OKAY;
			if (rdAccess)
				hrdata <= readValue;
		end
	end

	// latch write address until its data phase
	always_ff @(posedge clk) begin
		if (reset) begin
			wrPending <= 1'b0;
			wrAddr    <= 32'h0000_0000;
		end else begin
			wrPending <= wrAccess;
			if (wrAccess)
				wrAddr <= haddr;
		end
	end

	// control register; launch self-clears when the sequence ends
	always_ff @(posedge clk) begin
		if (reset)
			control <= serial_master_pkg::CTRL_RESET;
		else if (xferDone)
			control[serial_master_pkg::CTRL_LAUNCH] <= 1'b0;
		else if (wrCtrl)
			control <= hwdata[CTRL_WIDTH_L-1:0];
	end

	// divider and slave select registers
	always_ff @(posedge clk) begin
		if (reset) begin
			divider  <= serial_master_pkg::DIVIDER_RESET;
			slaveSel <= serial_master_pkg::SELECT_RESET;
		end else begin
			if (wrDiv)
				divider <= hwdata[DIV_WIDTH-1:0];
			if (wrSel)
				slaveSel <= hwdata[1:0];
		end
	end

	// data register: software load while idle, received bits while running;
	// a write mid-transfer is dropped so the capture is not corrupted
	always_ff @(posedge clk) begin
		if (reset)
			shiftData <= serial_master_pkg::DATA_RESET;
		else if (running) begin
			if (rxEdge & rxMore)
				shiftData[rxPos] <= rxBit;
		end else if (wrData)
			shiftData <= hwdata;
	end

	// state machine
	always_ff @(posedge clk) begin
		if (reset)
			state <= serial_master_pkg::ST_IDLE;
		else begin
			case (state)
				serial_master_pkg::ST_IDLE: begin
					if (startXfer)
						state <= serial_master_pkg::ST_RUN;
				end
				serial_master_pkg::ST_RUN: begin
					if (lastEdge)
						state <= serial_master_pkg::ST_IDLE;
				end
				default: state <= serial_master_pkg::ST_IDLE;
			endcase
		end
	end

	// prescaler: reload on launch and at each half period
	always_ff @(posedge clk) begin
		if (reset)
			divCount <= '0;
		else if (startXfer | halfDone)
			divCount <= divider;
		else if (running)
			divCount <= divCount - 1'b1;
	end

	// internal clock phase and edge counter
	always_ff @(posedge clk) begin
		if (reset) begin
			phase     <= 1'b0;
			edgeCount <= '0;
		end else begin
			phase <= next_phase;
			if (startXfer)
				edgeCount <= '0;
			else if (halfDone)
				edgeCount <= edgeCount + 1'b1;
		end
	end

	// transmit word captured at launch so received bits can overwrite
	always_ff @(posedge clk) begin
		if (reset)
			txWord <= 32'h0000_0000;
		else if (startXfer)
			txWord <= shiftData;
	end

	// serial data out; falling-edge transmit puts the first bit out at launch
	always_ff @(posedge clk) begin
		if (reset) begin
			mosi    <= 1'b0;
			txCount <= '0;
		end else if (startXfer) begin
			if (hwdata[serial_master_pkg::CTRL_TX_FALL]) begin
				mosi    <= shiftData[bitPos('0,
					hwdata[serial_master_pkg::CTRL_LEN_HI:
					serial_master_pkg::CTRL_LEN_LO],
					hwdata[serial_master_pkg::CTRL_LSB])];
				txCount <= CW'(1);
			end else
				txCount <= '0;
		end else if (txEdge & txMore) begin
			mosi    <= txWord[txPos];
			txCount <= txCount + 1'b1;
		end
	end

	// receive counter
	always_ff @(posedge clk) begin
		if (reset)
			rxCount <= '0;
		else if (startXfer)
			rxCount <= '0;
		else if (rxEdge & rxMore)
			rxCount <= rxCount + 1'b1;
	end

	// pins: clock polarity applied at the pin, selects active low
	always_ff @(posedge clk) begin
		if (reset) begin
			sclk    <= 1'b0;
			selectN <= 2'h3;
		end else begin
			sclk    <= next_phase ^ sclkInv;
			selectN <= ~slaveSel;
		end
	end

	// interrupt: completion sets, any access clears, set wins
	always_ff @(posedge clk) begin
		if (reset)
			irq <= 1'b0;
		else if (xferDone & irqEn)
			irq <= 1'b1;
		else if (addrPhase)
			irq <= 1'b0;
	end
endmodule : serial_master_control
`default_nettype wire

// file: testbench/serial_master_control_props.sv
`default_nettype none
module serial_master_control_props (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// bus side
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// serial side
	input wire logic        sclk,
	input wire logic        mosi,
	input wire logic [1:0]  selectN,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// requests taken this cycle; write data lands one edge later
	wire logic acc = hsel && hready && htrans[1];
	wire logic wr  = acc && hwrite;
	sequence s_done;
		$rose(irq);
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or erred");
	a_irq_clears: assert property (irq && acc |-> ##[1:2] !irq)
		else $error("interrupt survived a register access");
	a_irq_holds: assert property (irq && !acc && !$past(acc) |=> irq)
		else $error("interrupt dropped without an access");
	a_irq_at_edge: assert property (s_done |-> $changed(sclk))
		else $error("interrupt not tied to the last clock edge");
	a_idle_after: assert property (s_done |=> $stable(sclk) && $stable(mosi))
		else $error("serial lines moved after completion");
	a_mosi_moves: assert property (
		$changed(mosi) |-> $changed(sclk) || $past(wr, 2))
		else $error("data out changed between clock edges");
	a_select_write: assert property ($changed(selectN) |->
		$past(wr, 3) && $past(haddr, 3) == serial_master_pkg::ADDR_SELECT)
		else $error("select lines changed without a write");
	a_read_data: assert property (
		$changed(hrdata) |-> $past(acc) && !$past(hwrite))
		else $error("read data changed outside a read");
endmodule : serial_master_control_props
`default_nettype wire

// file: testbench/serial_slave_model.sv
`default_nettype none
module serial_slave_model #(
	parameter logic [31:0] PATTERN = 32'hc5a3_96e1
) (
	// serial link
	input wire logic        sclk,
	input wire logic        selectN,
	input wire logic        mosi,
	output logic            miso,
	// bits seen on data out, newest at bit 0
	output logic [31:0]     got
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] sh = PATTERN;
	// reply moves on falling edges so it is settled for a rising sample;
	// deselected, the line shows the opposite level instead of holding
	assign miso = selectN ? ~sh[31] : sh[31];
	always @(negedge sclk, posedge selectN) begin
		if (selectN)
			sh <= PATTERN;
		else
			sh <= sh << 1;
	end
	// capture on rising edges, where the master keeps data out still
	always @(posedge sclk) got <= {got[30:0], mosi};
endmodule : serial_slave_model
`default_nettype wire

// file: testbench/serial_master_control_bench.sv
`default_nettype none
module serial_master_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] PAT = 32'hc5a3_96e1;
	typedef struct packed {
		logic [4:0]  len;
		logic        lsb;
		logic        lb;
		logic        alt;
		logic [15:0] div;
		logic [31:0] data;
	} row_t;
	// length, order, loopback, swapped edges, divider, data word
	localparam row_t ROWS [5] = '{
		'{5'h00, 1'b0, 1'b0, 1'b0, 16'h0000, 32'h0000_0001},
		'{5'h01, 1'b0, 1'b0, 1'b0, 16'h0001, 32'hffff_fffe},
		'{5'h1f, 1'b1, 1'b0, 1'b0, 16'h0000, 32'h1234_5678},
		'{5'h0f, 1'b0, 1'b0, 1'b0, 16'h0002, 32'habcd_9ab1},
		'{5'h07, 1'b1, 1'b1, 1'b1, 16'h0003, 32'h5555_00a6}
	};
	logic        clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
	logic [31:0] hrdata, got;
	logic        hreadyout, hresp, sclk, mosi, miso, irq;
	logic [1:0]  selectN;
	int          errors = 0, check_count = 0, n;
	// one slave, so its ready is the bus ready
	serial_master_control i_dut (
		.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .sclk(sclk), .mosi(mosi), .miso(miso),
		.selectN(selectN), .irq(irq));
	serial_slave_model #(.PATTERN(PAT)) i_slave (
		.sclk(sclk), .selectN(selectN[0]), .mosi(mosi), .miso(miso),
		.got(got));
	always #2 clk = ~clk;
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// single word transfer; read data is taken at the data-phase edge
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel   <= 1'b1;
		htrans <= serial_master_pkg::HTRANS_NONSEQ;
		haddr  <= a;
		hwrite <= w;
		do @(posedge clk); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (!hreadyout);
		rd = hrdata;
	endtask : bus
	task automatic run(input row_t r);
		logic [31:0] c, m, t, v;
		int p;
		c = {20'h0_0000, r.lb, 2'b01, r.lsb, r.len, ~r.alt, r.alt, 1'b0};
		m = 32'hffff_ffff >> (5'd31 - r.len);
		v = r.data;
		t = 32'h0000_0000;
		for (int i = 0; i <= r.len; i++) begin
			p = r.lsb ? i : r.len - i;
			v[p] = r.lb ? ~r.data[p] : PAT[31 - i];
			t[r.len - i] = r.data[p];
		end
		// reselect so the slave starts its reply from the top
		bus(1'b1, serial_master_pkg::ADDR_SELECT, 32'h0000_0000);
		bus(1'b1, serial_master_pkg::ADDR_SELECT, 32'h0000_0001);
		bus(1'b1, serial_master_pkg::ADDR_DIVIDER, {16'h0000, r.div});
		bus(1'b1, serial_master_pkg::ADDR_SHIFT_DATA, r.data);
		bus(1'b1, serial_master_pkg::ADDR_CONTROL, c);
		bus(1'b1, serial_master_pkg::ADDR_CONTROL, c | 32'h0000_0001);
		n = 0;
		while (!irq) begin
			@(posedge clk);
			n++;
		end
		chk(n, 2 * (r.len + 1) * (r.div + 1) + 1);
		bus(1'b0, serial_master_pkg::ADDR_SHIFT_DATA, 32'h0000_0000);
		chk(rd, v);
		bus(1'b0, serial_master_pkg::ADDR_CONTROL, 32'h0000_0000);
		chk(rd, c);
		chk(irq, 1'b0);
		if (!r.lb)
			chk(got & m, t);
	endtask : run
	// reset values, the table of transfers, then the odd corners
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk(selectN, 2'b11);
		bus(1'b0, serial_master_pkg::ADDR_CONTROL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		bus(1'b0, 32'h8000_0100, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		foreach (ROWS[k])
			run(ROWS[k]);
		chk(selectN, 2'b10);
		bus(1'b1, serial_master_pkg::ADDR_CONTROL, 32'h0000_0400);
		bus(1'b0, serial_master_pkg::ADDR_SELECT, 32'h0000_0000);
		chk(sclk, 1'b1);
		// reset in mid-transfer: sclk, selects, irq and the control register go back to rest
		bus(1'b1, serial_master_pkg::ADDR_CONTROL, 32'h0000_0238);
		bus(1'b1, serial_master_pkg::ADDR_CONTROL, 32'h0000_0239);
		repeat (3) @(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk(sclk, 1'b0);
		chk(selectN, 2'b11);
		chk(irq, 1'b0);
		bus(1'b0, serial_master_pkg::ADDR_CONTROL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		end_of_test();
	end
	// no row needs more than a few hundred cycles; this only ends a hang
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		end_of_test();
	end
endmodule : serial_master_control_bench
bind serial_master_control serial_master_control_props i_props (
	.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .sclk(sclk), .mosi(mosi), .selectN(selectN), .irq(irq));
`default_nettype wire
